// ==== logic/ems_pkg.sv ====
// Constants and carriers for the expanded-memory page mapper.
// Assumes a 16-bit I/O address space and a 24-bit memory address bus.
package ems_pkg;
   // I/O port decoding: high byte, low nibble; the middle nibble is a module parameter
   localparam logic [7:0] PORT_FRAME_BASE_HI = 8'h02;
   localparam logic [7:0] PORT_POINTER_HI = 8'h12;
   localparam logic [3:0] PORT_FRAME_BASE_LO = 4'ha;
   localparam logic [3:0] PORT_POINTER_LO = 4'ha;
   localparam logic [3:0] PORT_WINDOW_LO = 4'hb;
   localparam logic [3:0] PORT_UPPER_LOW_LO = 4'h8;
   localparam logic [3:0] PORT_UPPER_HIGH_LO = 4'h9;
   localparam logic [3:0] PORT_UPPER_HI_NIB = 4'h2;
   // Frame base register fields
   localparam int FB_PORT_EN_BIT = 7;
   localparam int FB_WAIT_BIT = 6;
   localparam logic [3:0] FB_CODE_MAX = 4'h8;
   localparam logic [7:0] FRAME_BASE_RESET = 8'h00;
   // Page pointer fields
   localparam int PTR_SET_BIT = 6;
   localparam int PTR_HIGH_BIT = 0;
   localparam logic [6:0] POINTER_RESET = 7'h00;
   // Page register fields
   localparam int PG_ENABLE_BIT = 7;
   localparam logic [15:0] PAGE_RESET = 16'h0000;
   // Memory map, in units of 16 KB frames (address bits 19:14)
   localparam logic [5:0] UPPER_FIRST_FRAME = 6'h30;
   localparam logic [5:0] LOWER_FIRST_FRAME = 6'h10;
   localparam logic [5:0] LOWER_LAST_FRAME = 6'h2f;
   localparam int OFFSET_W = 14;
   localparam int PN_W = 11;
   localparam int MEM_AW = 24;
   localparam int PHYS_AW = PN_W + OFFSET_W;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } io_req_t;

   typedef struct packed {
      logic valid;
      logic mapped;
      logic wait_state;
      logic [PN_W-1:0] page_number;
      logic [PHYS_AW-1:0] phys_addr;
   } map_res_t;
endpackage

// ==== logic/ems_page_mapper.sv ====
// Expanded-memory page mapper: I/O-programmed page registers and the memory lookup.
// Assumes single-cycle I/O strobes and a one-cycle memory request pulse on clk.
//
// Notes on behaviour
// - Frame base bit 7 enables the pointer, data and upper page ports when set and disables them when clear; the frame base port stays live.
// - Frame base bit 6 adds exactly one wait state to accesses in the upper range, none when clear.
// - The 4-bit frame code places four 16 KB slots from C0000h plus code times 4000h, up to E0000h.
// - Upper page registers 0 to 3 map to slots 0 to 3 of the placed frame in set 0, registers 4 to 7 in set 1.
// - Upper page registers are byte pairs at x8 and x9 ports, set 0 at 02/42/82/C2 and set 1 at 12/52/92/D2.
// - Upper page registers hold the 16-bit page data for their slot written as low and high byte.
// - The page pointer selects one of 64 page registers for 16 KB frames from 40000h to BFFFFh.
// - A tagged access below 1 MB derives its index from the frame, 00/01..3E/3F in set 0, 40/41..7E/7F in set 1.
// - Software writes the write-only pointer port, and the data port then exposes the selected page register.
// - The data port shows only the page register selected by the pointer, byte by byte.
// - Pointer bit 6 selects the active set and the set written next, set 0 after reset, switching all maps at once.
// - Pointer bits 5 to 1 give the page register index used while configuring.
// - Pointer bit 0 selects low or high byte and toggles after each data-port access.
// - Low-byte bit 7 of a page register enables mapping for its frame.
// - Low-byte bits 6 to 0 give page_number 6..0 and the high-byte low nibble gives the upper bits.
// - The selected page register's page number goes to the memory controller for the access.
`timescale 1ns/10ps
`default_nettype none
module ems_page_mapper
   import ems_pkg::*;
#(
   parameter logic [3:0] PORT_MID_NIB = 4'h0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [7:0] io_rdata,
   output logic io_rdata_valid,
   input wire logic [MEM_AW-1:0] mem_addr,
   input wire logic mem_req,
   input wire logic ems_tag,
   output logic map_valid,
   output logic map_enable,
   output logic map_wait,
   output logic [PN_W-1:0] page_number,
   output logic [PHYS_AW-1:0] phys_addr
);

   // Page number from a 16-bit page register image
   function automatic logic [PN_W-1:0] pn_of(input logic [15:0] r);
      pn_of = {r[11:8], r[6:0]};
   endfunction

   io_req_t req;
   map_res_t res;
   logic [7:0] frame_base_ff;
   logic [6:0] pointer_ff;
   logic [15:0] lower_ff [64];
   logic [15:0] upper_ff [8];
   logic [7:0] io_rdata_ff;
   logic io_rdata_valid_ff;
   map_res_t res_ff;

   assign req = '{addr: io_addr, wdata: io_wdata, wr: io_wr, rd: io_rd};

   // Port decode; the frame base port stays live so the ports can be re-enabled
   wire ports_on = frame_base_ff[FB_PORT_EN_BIT];
   wire mid_ok = (req.addr[7:4] == PORT_MID_NIB);
   wire hit_fb = mid_ok && req.addr[15:8] == PORT_FRAME_BASE_HI &&
                 req.addr[3:0] == PORT_FRAME_BASE_LO;
   wire hit_ptr = ports_on && mid_ok && req.addr[15:8] == PORT_POINTER_HI &&
                  req.addr[3:0] == PORT_POINTER_LO;
   wire hit_win = ports_on && mid_ok && req.addr[15:8] == PORT_POINTER_HI &&
                  req.addr[3:0] == PORT_WINDOW_LO;
   wire upper_port = ports_on && mid_ok && req.addr[11:8] == PORT_UPPER_HI_NIB &&
                     !req.addr[13] &&
                     (req.addr[3:0] == PORT_UPPER_LOW_LO ||
                      req.addr[3:0] == PORT_UPPER_HIGH_LO);
   wire upper_high = req.addr[0]; // x9 is the high byte
   wire [2:0] upper_sel = {req.addr[12], req.addr[15:14]};

   // Window selection by the pointer
   wire set_sel = pointer_ff[PTR_SET_BIT];
   wire [5:0] win_idx = {set_sel, pointer_ff[5:1]};
   wire win_high = pointer_ff[PTR_HIGH_BIT];
   wire [15:0] win_reg = lower_ff[win_idx];
   wire [7:0] win_byte = win_high ? win_reg[15:8] : win_reg[7:0];
   wire [15:0] up_reg = upper_ff[upper_sel];
   wire [7:0] up_byte = upper_high ? up_reg[15:8] : up_reg[7:0];
   wire win_access = hit_win && (req.wr || req.rd);

   // Pointer: write-only; byte select toggles after each window access
   logic [6:0] nxt_pointer;
   always_comb begin
      nxt_pointer = pointer_ff;
      if (hit_ptr && req.wr) begin
         nxt_pointer = req.wdata[6:0];
      end else if (win_access) begin
         nxt_pointer[PTR_HIGH_BIT] = !pointer_ff[PTR_HIGH_BIT];
      end
   end

   // Read data: pointer and frame base are write-only and read as zero
   logic [7:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 8'h00;
      if (hit_win) begin
         nxt_rdata = win_byte;
      end else if (upper_port) begin
         nxt_rdata = up_byte;
      end
   end

   // Upper range lookup
   wire [3:0] code = frame_base_ff[3:0];
   wire [5:0] mem_frame = mem_addr[19:14];
   wire below_1m = (mem_addr[MEM_AW-1:20] == '0);
   wire [5:0] up_rel = mem_frame - (UPPER_FIRST_FRAME + {2'b00, code});
   wire in_upper = below_1m && code <= FB_CODE_MAX && up_rel < 6'd4;
   wire [15:0] up_map = upper_ff[{set_sel, up_rel[1:0]}];

   // Lower range lookup
   wire in_lower = below_1m && ems_tag && mem_frame >= LOWER_FIRST_FRAME &&
                   mem_frame <= LOWER_LAST_FRAME;
   wire [5:0] low_rel = mem_frame - LOWER_FIRST_FRAME;
   wire [15:0] low_map = lower_ff[{set_sel, low_rel[4:0]}];

   wire [15:0] sel_map = in_upper ? up_map : low_map;
   wire sel_en = (in_upper || in_lower) && sel_map[PG_ENABLE_BIT];
   wire [PN_W-1:0] sel_pn = pn_of(sel_map);

   always_comb begin
      res.valid = mem_req;
      res.mapped = sel_en;
      res.wait_state = in_upper && frame_base_ff[FB_WAIT_BIT];
      res.page_number = sel_en ? sel_pn : '0;
      if (sel_en) begin
         res.phys_addr = {sel_pn, mem_addr[OFFSET_W-1:0]};
      end else begin
         res.phys_addr = {{(PHYS_AW-MEM_AW){1'b0}}, mem_addr};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         frame_base_ff <= FRAME_BASE_RESET;
      end else if (hit_fb && req.wr) begin
         frame_base_ff <= req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pointer_ff <= POINTER_RESET;
      end else begin
         pointer_ff <= nxt_pointer;
      end
   end

   // Window writes land in the set and byte chosen by the pointer
   genvar gi;
   generate
      for (gi = 0; gi < 64; gi++) begin : g_lower
         always_ff @(posedge clk) begin
            if (!resetn) begin
               lower_ff[gi] <= PAGE_RESET;
            end else if (hit_win && req.wr && win_idx == 6'(gi)) begin
               if (win_high) begin
                  lower_ff[gi][15:8] <= req.wdata;
               end else begin
                  lower_ff[gi][7:0] <= req.wdata;
               end
            end
         end
      end
      for (gi = 0; gi < 8; gi++) begin : g_upper
         always_ff @(posedge clk) begin
            if (!resetn) begin
               upper_ff[gi] <= PAGE_RESET;
            end else if (upper_port && req.wr && upper_sel == 3'(gi)) begin
               if (upper_high) begin
                  upper_ff[gi][15:8] <= req.wdata;
               end else begin
                  upper_ff[gi][7:0] <= req.wdata;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!resetn) begin
         io_rdata_ff <= 8'h00;
         io_rdata_valid_ff <= 1'b0;
      end else begin
         io_rdata_ff <= req.rd ? nxt_rdata : 8'h00;
         io_rdata_valid_ff <= req.rd && (hit_win || upper_port);
      end
   end

   // Result is registered: one cycle from request to memory controller
   always_ff @(posedge clk) begin
      if (!resetn) begin
         res_ff <= '0;
      end else begin
         res_ff <= res;
      end
   end

   assign io_rdata = io_rdata_ff;
   assign io_rdata_valid = io_rdata_valid_ff;
   assign map_valid = res_ff.valid;
   assign map_enable = res_ff.mapped;
   assign map_wait = res_ff.wait_state;
   assign page_number = res_ff.page_number;
   assign phys_addr = res_ff.phys_addr;

endmodule // ems_page_mapper
`default_nettype wire

// ==== verif/ems_page_mapper_asserts.sv ====
// Port checker for the page mapper.
// Bound to every mapper; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module ems_page_mapper_asserts
   import ems_pkg::*;
#(parameter logic [3:0] PORT_MID_NIB = 4'h0) (
   input wire logic clk, input wire logic resetn, input wire logic [15:0] io_addr,
   input wire logic io_rd, input wire logic [7:0] io_rdata, input wire logic io_rdata_valid,
   input wire logic [MEM_AW-1:0] mem_addr, input wire logic mem_req, input wire logic ems_tag,
   input wire logic map_valid, input wire logic map_enable, input wire logic map_wait,
   input wire logic [PN_W-1:0] page_number, input wire logic [PHYS_AW-1:0] phys_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   valid_follows_a: assert property (map_valid == $past(mem_req))
      else $error("map_valid not one cycle after mem_req");
   unmapped_pass_a: assert property (map_valid && !map_enable |->
      phys_addr == {1'b0, $past(mem_addr)} && page_number == '0) else $error("bad pass");
   mapped_addr_a: assert property (map_valid && map_enable |->
      phys_addr == {page_number, $past(mem_addr[13:0])}) else $error("bad mapped address");
   wait_upper_a: assert property (map_valid && map_wait |->
      $past(mem_addr[23:16]) inside {8'h0c, 8'h0d, 8'h0e}) else $error("wait out of range");
   lower_tag_a: assert property (map_valid && map_enable && $past(mem_addr[23:16]) < 8'h0c
      |-> $past(ems_tag)) else $error("untagged lower map");
   read_answer_a: assert property (io_rdata_valid |-> $past(io_rd))
      else $error("read data without read");
   idle_zero_a: assert property (!io_rdata_valid |-> io_rdata == 8'h00)
      else $error("read data not zero");
   pointer_wo_a: assert property (io_rd && io_addr == {8'h12, PORT_MID_NIB, 4'ha}
      |=> !io_rdata_valid) else $error("pointer readable");
endmodule // ems_page_mapper_asserts
bind ems_page_mapper ems_page_mapper_asserts #(.PORT_MID_NIB(PORT_MID_NIB)) chk_inst (
   .clk(clk), .resetn(resetn), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
   .io_rdata_valid(io_rdata_valid), .mem_addr(mem_addr), .mem_req(mem_req), .ems_tag(ems_tag),
   .map_valid(map_valid), .map_enable(map_enable), .map_wait(map_wait),
   .page_number(page_number), .phys_addr(phys_addr));
`default_nettype wire

// ==== verif/cpu_bus_model.sv ====
// Processor-side model: I/O strobes and memory requests.
// Assumes the mapper samples on the rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model
   import ems_pkg::*;
(
   input wire logic clk, output var io_req_t io, output var logic [MEM_AW-1:0] mem_addr,
   output var logic mem_req, output var logic ems_tag
);
   initial {io, mem_addr, mem_req, ems_tag} = '0;
   // Released address and data lines show the inverse, so a stale value is never trusted
   task automatic io_op(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      #1 io = '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      #1 io = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   task automatic lookup(input logic [MEM_AW-1:0] a, input logic t);
      @(posedge clk);
      #1 {mem_addr, mem_req, ems_tag} = {a, 1'b1, t};
      @(posedge clk);
      #1 {mem_addr, mem_req} = {~a, 1'b0};
   endtask
endmodule // cpu_bus_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the page mapper.
// Requests come from cpu_bus_model; 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ems_pkg::*;
   logic clk, resetn, mem_req, ems_tag, io_rdata_valid, map_valid, map_enable, map_wait;
   io_req_t io;
   logic [MEM_AW-1:0] mem_addr;
   logic [7:0] io_rdata;
   logic [PN_W-1:0] page_number;
   logic [PHYS_AW-1:0] phys_addr;
   int n_mismatch = 0, n_compared = 0, cycles = 0;
   cpu_bus_model cpu_bus_model_inst (.clk(clk), .io(io), .mem_addr(mem_addr),
      .mem_req(mem_req), .ems_tag(ems_tag));
   ems_page_mapper ems_page_mapper_inst (.clk(clk), .resetn(resetn), .io_addr(io.addr),
      .io_wdata(io.wdata), .io_wr(io.wr), .io_rd(io.rd), .io_rdata(io_rdata),
      .io_rdata_valid(io_rdata_valid), .mem_addr(mem_addr), .mem_req(mem_req),
      .ems_tag(ems_tag), .map_valid(map_valid), .map_enable(map_enable),
      .map_wait(map_wait), .page_number(page_number), .phys_addr(phys_addr));
   task automatic fail(input logic [31:0] g, e);
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      cpu_bus_model_inst.io_op(a, d, 1'b1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [8:0] e);
      cpu_bus_model_inst.io_op(a, 8'h00, 1'b0);
      n_compared++;
      if ({io_rdata_valid, io_rdata} !== e) fail(32'({io_rdata_valid, io_rdata}), 32'(e));
   endtask
   task automatic lk(input logic [23:0] a, input logic t, en, w, input logic [10:0] pn);
      map_res_t g, e;
      cpu_bus_model_inst.lookup(a, t);
      g = '{map_valid, map_enable, map_wait, page_number, phys_addr};
      e = '{1'b1, en, w, en ? pn : 11'h0, en ? {pn, a[13:0]} : {1'b0, a}};
      n_compared++;
      if (g !== e) fail(32'(g), 32'(e));
   endtask
   task automatic t_reset;
      rd(16'h0208, 9'h000);
      lk(24'h0c4000, 1'b1, 1'b0, 1'b0, 11'h0);
      $display("t_reset done");
   endtask
   task automatic t_upper;
      wr(16'h020a, 8'hc8);
      for (int s = 0; s < 4; s++) begin
         wr({s[1:0], 6'h02, 8'h08}, 8'h80 | 8'(s));
         wr({s[1:0], 6'h02, 8'h09}, 8'hf5);
         rd({s[1:0], 6'h02, 8'h08}, {1'b1, 8'h80 | 8'(s)});
         lk({4'h0, 6'h38 + 6'(s), 14'h0123}, 1'b1, 1'b1, 1'b1, {4'h5, 7'(s)});
      end
      lk(24'h0f0000, 1'b1, 1'b0, 1'b0, 11'h0);
      wr(16'h020a, 8'h88);
      lk(24'h0e0000, 1'b1, 1'b1, 1'b0, 11'h280);
      $display("t_upper done");
   endtask
   task automatic t_lower;
      wr(16'h120a, 8'h42);
      wr(16'h120b, 8'h85);
      wr(16'h120b, 8'h03);
      rd(16'h120b, 9'h185);
      rd(16'h120b, 9'h103);
      lk(24'h044123, 1'b1, 1'b1, 1'b0, 11'h185);
      lk(24'h044123, 1'b0, 1'b0, 1'b0, 11'h0);
      wr(16'h120a, 8'h02);
      lk(24'h044123, 1'b1, 1'b0, 1'b0, 11'h0);
      wr(16'h1208, 8'h9a);
      wr(16'h120a, 8'h40);
      lk(24'h0e0000, 1'b1, 1'b1, 1'b0, 11'h01a);
      $display("t_lower done");
   endtask
   task automatic t_disable;
      wr(16'h020a, 8'h08);
      wr(16'h0208, 8'hff);
      rd(16'h0208, 9'h000);
      wr(16'h020a, 8'h88);
      rd(16'h0208, 9'h180);
      rd(16'h020a, 9'h000);
      rd(16'h120a, 9'h000);
      $display("t_disable done");
   endtask
   task automatic results;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run needs about 85 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      t_reset();
      t_upper();
      t_lower();
      t_disable();
      results();
   end
endmodule // tb
`default_nettype wire
